// File: src/rss_glitch_filter.sv
// Glitch filter: output follows input only after it stays stable
`timescale 1ns/1ps
module rss_glitch_filter #(
  parameter int   FILT_CYCLES = 100,
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  localparam int CNT_W = $clog2(FILT_CYCLES + 1);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             level_reg;
  logic             level_next;

  generate
    if (FILT_CYCLES < 1)
    begin : g_bad
      $error("rss_glitch_filter: FILT_CYCLES must be at least 1");
    end
  endgenerate

  // Count cycles of disagreement; any return resets the count
  always_comb
  begin
    cnt_next   = '0;
    level_next = level_reg;
    if (din != level_reg)
    begin
      if (cnt_reg == CNT_W'(FILT_CYCLES - 1))
        level_next = din;
      else
        cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg   <= '0;
      level_reg <= RESET_LEVEL;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      level_reg <= level_next;
    end
  end

  assign dout = level_reg;

endmodule

// File: src/rss_pkg.sv
// Shared constants for the reset and start-up sequencer
package rss_pkg;

  // Clock rate of mclk
  localparam int CLK_FREQ_HZ      = 50_000_000;
  localparam int CLK_PERIOD_NS    = 20;

  // Power-up delay, nominal, in its own unit
  localparam int POWER_UP_TIMER_TIME_MS     = 72;
  localparam int POWER_UP_TIMER_CYCLES      = (CLK_FREQ_HZ / 1000) * POWER_UP_TIMER_TIME_MS;

  // Oscillator start-up count, in oscillator input cycles
  localparam int OST_COUNT        = 1024;

  // Reset pin glitch filter; least qualifying width, rounded up
  localparam int PIN_FILTER_NS    = 2000;
  localparam int PIN_FILTER_CYCLES =
    (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Brown-out qualifying time; least width, rounded up
  localparam int BOD_QUALIFY_NS   = 100_000;
  localparam int BOD_QUALIFY_CYCLES =
    (BOD_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Oscillator selection codes
  localparam logic [2:0] OSC_LP_XTAL     = 3'h0;
  localparam logic [2:0] OSC_STD_XTAL    = 3'h1;
  localparam logic [2:0] OSC_HS_XTAL     = 3'h2;
  localparam logic [2:0] OSC_EXT_CLOCK   = 3'h3;
  localparam logic [2:0] OSC_INT_IO      = 3'h4;
  localparam logic [2:0] OSC_INT_CLOCK_OUTPUT_PIN  = 3'h5;
  localparam logic [2:0] OSC_RC_IO       = 3'h6;
  localparam logic [2:0] OSC_RC_CLOCK_OUTPUT_PIN   = 3'h7;

  // Reset cause bit positions, one-hot
  localparam int CAUSE_W          = 6;
  localparam int CAUSE_POWER_ON   = 0;
  localparam int CAUSE_WDT_RUN    = 1;
  localparam int CAUSE_WDT_SLEEP  = 2;
  localparam int CAUSE_PIN_RUN    = 3;
  localparam int CAUSE_PIN_SLEEP  = 4;
  localparam int CAUSE_BROWN_OUT  = 5;

  // Async input positions in the synchroniser bank
  localparam int SYNC_W           = 4;
  localparam int SYNC_PIN         = 0;
  localparam int SYNC_BROWN       = 1;
  localparam int SYNC_SUPPLY      = 2;
  localparam int SYNC_OSC         = 3;

  // Clock output divider
  localparam int CLKDIV_W         = 2;

  // Sequencer states
  typedef enum logic [2:0]
  {
    ST_POWER_ON,
    ST_BROWN_OUT,
    ST_POWER_UP,
    ST_OSC_START,
    ST_PIN_HOLD,
    ST_RUN,
    ST_WAKE_START
  } rss_state_t;

endpackage

// File: src/rss_reset_sequencer.sv
// Reset merge, start-up timing and cause flags for a small controller
`timescale 1ns/1ps
module rss_reset_sequencer #(
  parameter int POWER_UP_TIMER_CYCLES   = rss_pkg::POWER_UP_TIMER_CYCLES,
  parameter int BOD_CYCLES    = rss_pkg::BOD_QUALIFY_CYCLES,
  parameter int OST_CYCLES    = rss_pkg::OST_COUNT,
  parameter int FILTER_CYCLES = rss_pkg::PIN_FILTER_CYCLES,
  parameter int RETAIN_W      = 8
) (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  input  wire logic [2:0]                   osc_mode_sel,
  input  wire logic                         power_up_timer_disable_bit,
  input  wire logic                         brown_out_enable_bit,
  input  wire logic                         reset_pin_function_bit,
  input  wire logic                         external_reset_pin_n,
  input  wire logic                         supply_adequate,
  input  wire logic                         supply_below_brown_out,
  input  wire logic                         osc_input,
  input  wire logic                         watchdog_timeout,
  input  wire logic                         sleeping,
  input  wire logic                         sleep_cmd,
  input  wire logic                         clear_watchdog_cmd,
  input  wire logic                         retain_we,
  input  wire logic [RETAIN_W-1:0]          retain_wdata,
  output logic [RETAIN_W-1:0]               retain_rdata,
  output logic                              core_reset_n,
  output logic                              core_run,
  output logic                              wake_pulse,
  output logic                              timeout_flag,
  output logic                              power_down_flag,
  output logic [rss_pkg::CAUSE_W-1:0]       reset_cause,
  output logic                              gpio_pin_in,
  output logic                              clock_output_pin,
  output logic                              clock_output_oe
);

  localparam int TMR_MAX = (POWER_UP_TIMER_CYCLES > OST_CYCLES) ? POWER_UP_TIMER_CYCLES
                                                       : OST_CYCLES;
  localparam int TMR_W   = $clog2(TMR_MAX + 1);
  localparam int BOD_W   = $clog2(BOD_CYCLES + 1);

  generate
    if (POWER_UP_TIMER_CYCLES < 1 || OST_CYCLES < 1 || BOD_CYCLES < 1 ||
        FILTER_CYCLES < 1 || RETAIN_W < 1)
    begin : g_bad
      $error("rss_reset_sequencer: counts must be at least 1");
    end
  endgenerate

  logic [1:0]                   rst_sync_reg;
  logic                         rst_n;
  logic [rss_pkg::SYNC_W-1:0]   async_in;
  logic [rss_pkg::SYNC_W-1:0]   sync1_reg;
  logic [rss_pkg::SYNC_W-1:0]   sync2_reg;
  logic                         pin_filtered;
  logic                         pin_active;
  logic                         brown_low;
  logic                         supply_ok;
  logic                         osc_prev_reg;
  logic                         osc_edge;
  logic                         xtal_mode;
  logic                         power_up_timer_on;
  logic                         bod_trip;
  rss_pkg::rss_state_t          state_reg;
  rss_pkg::rss_state_t          state_next;
  logic [TMR_W-1:0]             tmr_reg;
  logic [TMR_W-1:0]             tmr_next;
  logic [BOD_W-1:0]             bod_cnt_reg;
  logic [BOD_W-1:0]             bod_cnt_next;
  logic                         from_por_reg;
  logic                         from_por_next;
  logic [rss_pkg::CAUSE_W-1:0]  cause_reg;
  logic [rss_pkg::CAUSE_W-1:0]  cause_next;
  logic                         to_reg;
  logic                         to_next;
  logic                         pd_reg;
  logic                         pd_next;
  logic                         wake_reg;
  logic                         wake_next;
  logic                         core_rst_n_reg;
  logic                         core_rst_n_next;
  logic                         core_run_reg;
  logic                         core_run_next;
  logic                         gpio_reg;
  logic                         gpio_next;
  logic [rss_pkg::CLKDIV_W-1:0] div_reg;
  logic [rss_pkg::CLKDIV_W-1:0] div_next;
  logic                         clk_out_reg;
  logic                         clk_out_next;
  logic                         clk_oe_reg;
  logic                         clk_oe_next;
  logic [RETAIN_W-1:0]          retain_reg;
  logic [RETAIN_W-1:0]          retain_next;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  assign async_in[rss_pkg::SYNC_PIN]    = external_reset_pin_n;
  assign async_in[rss_pkg::SYNC_BROWN]  = supply_below_brown_out;
  assign async_in[rss_pkg::SYNC_SUPPLY] = supply_adequate;
  assign async_in[rss_pkg::SYNC_OSC]    = osc_input;

  // Two-flop synchronisers, one per async input
  genvar gi;
  generate
    for (gi = 0; gi < rss_pkg::SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          // Pin idles high; a low reset value would look like a press
          sync1_reg[gi] <= (gi == rss_pkg::SYNC_PIN);
          sync2_reg[gi] <= (gi == rss_pkg::SYNC_PIN);
        end
        else
        begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign brown_low = sync2_reg[rss_pkg::SYNC_BROWN];
  assign supply_ok = sync2_reg[rss_pkg::SYNC_SUPPLY];
  assign osc_edge  = sync2_reg[rss_pkg::SYNC_OSC] & ~osc_prev_reg;

  rss_glitch_filter #(
    .FILT_CYCLES (FILTER_CYCLES),
    .RESET_LEVEL (1'b1)
  ) u_pin_filter (
    .clk   (mclk),
    .rst_n (rst_n),
    .din   (sync2_reg[rss_pkg::SYNC_PIN]),
    .dout  (pin_filtered)
  );

  // pin function off ties the reset input inactive
  // function bit selects reset or digital input
  assign pin_active = reset_pin_function_bit & ~pin_filtered;

  // Mode decode
  // start count only for crystal modes
  assign xtal_mode = (osc_mode_sel == rss_pkg::OSC_LP_XTAL) ||
                     (osc_mode_sel == rss_pkg::OSC_STD_XTAL) ||
                     (osc_mode_sel == rss_pkg::OSC_HS_XTAL);
  // disable bit high turns the delay off
  assign power_up_timer_on   = ~power_up_timer_disable_bit;

  // detection only with the enable bit set
  // low supply must persist the qualifying time
  always_comb
  begin
    bod_cnt_next = '0;
    if (brown_out_enable_bit && brown_low)
    begin
      if (bod_cnt_reg != BOD_W'(BOD_CYCLES))
        bod_cnt_next = bod_cnt_reg + BOD_W'(1);
      else
        bod_cnt_next = bod_cnt_reg;
    end
  end

  assign bod_trip = (bod_cnt_reg == BOD_W'(BOD_CYCLES));

  // Sequencer; hardware events win over software flag writes
  always_comb
  begin
    state_next    = state_reg;
    tmr_next      = tmr_reg;
    from_por_next = from_por_reg;
    cause_next    = cause_reg;
    to_next       = to_reg;
    pd_next       = pd_reg;
    wake_next     = 1'b0;
    // Software flag updates only take effect while running
    if (state_reg == rss_pkg::ST_RUN)
    begin
      if (sleep_cmd)
      begin
        to_next = 1'b1;
        pd_next = 1'b0;
      end
      if (clear_watchdog_cmd)
      begin
        to_next = 1'b1;
        pd_next = 1'b1;
      end
    end
    case (state_reg)
      rss_pkg::ST_POWER_ON:
      begin
        // wait for the supply, then check the brown-out level
        if (supply_ok)
        begin
          tmr_next = '0;
          // stay in reset until brown-out level is passed
          if (brown_out_enable_bit && brown_low)
            state_next = rss_pkg::ST_BROWN_OUT;
          // delay first, start count after it
          else if (power_up_timer_on)
            state_next = rss_pkg::ST_POWER_UP;
          else if (xtal_mode)
            state_next = rss_pkg::ST_OSC_START;
          // non-crystal mode with timer off, no delay
          else
            state_next = rss_pkg::ST_PIN_HOLD;
        end
      end
      rss_pkg::ST_BROWN_OUT:
      begin
        tmr_next = '0;
        if (!(brown_out_enable_bit && brown_low))
        begin
          // no delay with the timer disabled
          if (power_up_timer_on)
            state_next = rss_pkg::ST_POWER_UP;
          else if (xtal_mode && from_por_reg)
            state_next = rss_pkg::ST_OSC_START;
          else
            state_next = rss_pkg::ST_PIN_HOLD;
        end
      end
      rss_pkg::ST_POWER_UP:
      begin
        if (brown_out_enable_bit && brown_low)
        begin
          state_next = rss_pkg::ST_BROWN_OUT;
          tmr_next   = '0;
        end
        else if (tmr_reg == TMR_W'(POWER_UP_TIMER_CYCLES - 1))
        begin
          tmr_next = '0;
          if (xtal_mode && from_por_reg)
            state_next = rss_pkg::ST_OSC_START;
          else
            state_next = rss_pkg::ST_PIN_HOLD;
        end
        else
          tmr_next = tmr_reg + TMR_W'(1);
      end
      rss_pkg::ST_OSC_START, rss_pkg::ST_WAKE_START:
      begin
        if (bod_trip)
        begin
          state_next    = rss_pkg::ST_BROWN_OUT;
          tmr_next      = '0;
        end
        else if (state_reg == rss_pkg::ST_WAKE_START && pin_active)
        begin
          state_next = rss_pkg::ST_PIN_HOLD;
          cause_next = '0;
          cause_next[rss_pkg::CAUSE_PIN_SLEEP] = 1'b1;
          to_next    = 1'b1;
          pd_next    = 1'b0;
        end
        else if (osc_edge)
        begin
          if (tmr_reg == TMR_W'(OST_CYCLES - 1))
          begin
            tmr_next = '0;
            if (state_reg == rss_pkg::ST_WAKE_START)
            begin
              state_next = rss_pkg::ST_RUN;
              wake_next  = 1'b1;
            end
            else
              state_next = rss_pkg::ST_PIN_HOLD;
          end
          else
            tmr_next = tmr_reg + TMR_W'(1);
        end
      end
      rss_pkg::ST_PIN_HOLD:
      begin
        // delays already spent, release starts at once
        if (bod_trip)
          state_next = rss_pkg::ST_BROWN_OUT;
        else if (!pin_active)
          state_next = rss_pkg::ST_RUN;
      end
      rss_pkg::ST_RUN:
      begin
        from_por_next = 1'b0;
        tmr_next      = '0;
        // each cause sets its own bit
        if (bod_trip)
        begin
          state_next = rss_pkg::ST_BROWN_OUT;
          cause_next = '0;
          cause_next[rss_pkg::CAUSE_BROWN_OUT] = 1'b1;
          to_next    = 1'b1;
          pd_next    = 1'b1;
        end
        else if (pin_active)
        begin
          state_next = rss_pkg::ST_PIN_HOLD;
          cause_next = '0;
          if (sleeping)
          begin
            cause_next[rss_pkg::CAUSE_PIN_SLEEP] = 1'b1;
            to_next = 1'b1;
            pd_next = 1'b0;
          end
          else
          begin
            cause_next[rss_pkg::CAUSE_PIN_RUN] = 1'b1;
            to_next = to_reg;
            pd_next = pd_reg;
          end
        end
        else if (watchdog_timeout)
        begin
          cause_next = '0;
          to_next    = 1'b0;
          if (sleeping)
          begin
            cause_next[rss_pkg::CAUSE_WDT_SLEEP] = 1'b1;
            pd_next = 1'b0;
            // start count on wake in crystal modes
            if (xtal_mode)
              state_next = rss_pkg::ST_WAKE_START;
            else
              wake_next = 1'b1;
          end
          else
          begin
            cause_next[rss_pkg::CAUSE_WDT_RUN] = 1'b1;
            pd_next    = pd_reg;
            state_next = rss_pkg::ST_PIN_HOLD;
          end
        end
      end
      default:
      begin
        state_next = rss_pkg::ST_POWER_ON;
        tmr_next   = '0;
      end
    endcase
  end

  // core reset low except while running or waking
  assign core_rst_n_next = (state_next == rss_pkg::ST_RUN) ||
                           (state_next == rss_pkg::ST_WAKE_START);
  assign core_run_next   = (state_next == rss_pkg::ST_RUN);
  assign gpio_next       = reset_pin_function_bit ? 1'b0 : pin_filtered;

  // divide by four, driven only in clock-out modes
  assign div_next     = div_reg + rss_pkg::CLKDIV_W'(1);
  assign clk_out_next = div_reg[rss_pkg::CLKDIV_W-1];
  assign clk_oe_next  = (osc_mode_sel == rss_pkg::OSC_INT_CLOCK_OUTPUT_PIN) ||
                        (osc_mode_sel == rss_pkg::OSC_RC_CLOCK_OUTPUT_PIN);

  // Sequencer and output registers; power-on sets flags high
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg      <= rss_pkg::ST_POWER_ON;
      tmr_reg        <= '0;
      bod_cnt_reg    <= '0;
      from_por_reg   <= 1'b1;
      cause_reg      <= rss_pkg::CAUSE_W'(1) << rss_pkg::CAUSE_POWER_ON;
      to_reg         <= 1'b1;
      pd_reg         <= 1'b1;
      wake_reg       <= 1'b0;
      core_rst_n_reg <= 1'b0;
      core_run_reg   <= 1'b0;
      gpio_reg       <= 1'b0;
      osc_prev_reg   <= 1'b0;
      div_reg        <= '0;
      clk_out_reg    <= 1'b0;
      clk_oe_reg     <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      tmr_reg        <= tmr_next;
      bod_cnt_reg    <= bod_cnt_next;
      from_por_reg   <= from_por_next;
      cause_reg      <= cause_next;
      to_reg         <= to_next;
      pd_reg         <= pd_next;
      wake_reg       <= wake_next;
      core_rst_n_reg <= core_rst_n_next;
      core_run_reg   <= core_run_next;
      gpio_reg       <= gpio_next;
      osc_prev_reg   <= sync2_reg[rss_pkg::SYNC_OSC];
      div_reg        <= div_next;
      clk_out_reg    <= clk_out_next;
      clk_oe_reg     <= clk_oe_next;
    end
  end

  // no reset on purpose, contents survive every reset
  assign retain_next = retain_we ? retain_wdata : retain_reg;

  always_ff @(posedge mclk)
  begin
    retain_reg <= retain_next;
  end

  assign retain_rdata     = retain_reg;
  assign core_reset_n     = core_rst_n_reg;
  assign core_run         = core_run_reg;
  assign wake_pulse       = wake_reg;
  assign timeout_flag     = to_reg;
  assign power_down_flag  = pd_reg;
  assign reset_cause      = cause_reg;
  assign gpio_pin_in      = gpio_reg;
  assign clock_output_pin = clk_out_reg;
  assign clock_output_oe  = clk_oe_reg;

endmodule

// File: verification/rss_reset_sequencer_sva.sv
// Port checker for the reset and start-up sequencer
`timescale 1ns/1ps
module rss_reset_sequencer_sva (
  input wire logic                         mclk,
  input wire logic                         rstn,
  input wire logic [2:0]                   osc_mode_sel,
  input wire logic                         reset_pin_function_bit,
  input wire logic                         external_reset_pin_n,
  input wire logic                         supply_below_brown_out,
  input wire logic                         watchdog_timeout,
  input wire logic                         sleeping,
  input wire logic                         core_reset_n,
  input wire logic                         core_run,
  input wire logic                         wake_pulse,
  input wire logic                         timeout_flag,
  input wire logic                         power_down_flag,
  input wire logic [rss_pkg::CAUSE_W-1:0]  reset_cause,
  input wire logic                         clock_output_oe
);
  // One clock domain; the power-on pulse disables everything
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Six-cycle settle covers the internal reset release
  a_clock_output_pin_oe: assert property (
    $stable(osc_mode_sel) [*6]
    |-> clock_output_oe == (osc_mode_sel inside {3'h5, 3'h7}))
    else $error("clock out enable wrong for mode");
  a_cause_onehot: assert property (
    $onehot(reset_cause)) else $error("reset cause not one-hot");
  a_wdt_run: assert property (
    core_run && watchdog_timeout && !sleeping && external_reset_pin_n
    && !supply_below_brown_out |=> reset_cause == 6'h02 && !timeout_flag
    && !core_reset_n) else $error("watchdog reset in run wrong");
  a_wdt_wake: assert property (
    core_run && watchdog_timeout && sleeping && osc_mode_sel > 3'h2
    && external_reset_pin_n && !supply_below_brown_out |=> wake_pulse
    && reset_cause == 6'h04 && !timeout_flag && !power_down_flag
    && core_reset_n) else $error("watchdog wake wrong");
  a_pin_glitch: assert property (
    core_reset_n && $fell(external_reset_pin_n) ##1
    $rose(external_reset_pin_n) |-> core_reset_n [*6])
    else $error("short pin pulse caused reset");
  a_pin_off: assert property (
    (!supply_below_brown_out && !watchdog_timeout
    && !reset_pin_function_bit) [*4] ##0 core_reset_n |=> core_reset_n)
    else $error("disabled pin caused reset");
  a_brown_flags: assert property (
    $rose(reset_cause[5]) |-> timeout_flag && power_down_flag
    ##[0:1] !core_reset_n) else $error("brown-out flags wrong");
  a_pin_sleep: assert property (
    $rose(reset_cause[4]) |-> timeout_flag && !power_down_flag
    ##[0:1] !core_reset_n) else $error("pin sleep flags wrong");

  // Main scenarios reached
  c_wake: cover property (wake_pulse);
  c_brown: cover property ($rose(reset_cause[5]));
  c_run: cover property ($rose(core_reset_n));
endmodule

bind rss_reset_sequencer rss_reset_sequencer_sva u_sva (
  .mclk(mclk), .rstn(rstn), .osc_mode_sel(osc_mode_sel),
  .reset_pin_function_bit(reset_pin_function_bit),
  .external_reset_pin_n(external_reset_pin_n),
  .supply_below_brown_out(supply_below_brown_out),
  .watchdog_timeout(watchdog_timeout), .sleeping(sleeping),
  .core_reset_n(core_reset_n), .core_run(core_run),
  .wake_pulse(wake_pulse), .timeout_flag(timeout_flag),
  .power_down_flag(power_down_flag), .reset_cause(reset_cause),
  .clock_output_oe(clock_output_oe));

// File: verification/rss_reset_sequencer_tb_top.sv
// Self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
module rss_reset_sequencer_tb_top;
  localparam int PW = 20;
  localparam int OS = 8;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] mode = 3'h1;
  logic       pdis = 1'b0;
  logic       bod_en = 1'b0;
  logic       rpf = 1'b1;
  logic       wdt = 1'b0;
  logic       slp = 1'b0;
  logic       scmd = 1'b0;
  logic       ccmd = 1'b0;
  logic       we = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic       sup_on = 1'b0;
  logic       brown = 1'b0;
  logic       pin_low = 1'b0;
  logic       rst_seen = 1'b1;
  logic       ck_q;
  wire        sup_ok, below, pin_n, osc;
  wire        crst_n, crun, wake, to_f, pd_f, gpio, ck_oe, ck;
  wire  [7:0] rdata;
  wire  [rss_pkg::CAUSE_W-1:0] cause;
  logic [7:0] exp_q[$];
  int         num_errors = 0;
  int         tests_run = 0;
  int         n;

  // Clock at the package rate
  always #(rss_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;

  // Far side: supply, pin network and crystal
  rss_supply_model u_model (.sup_on(sup_on), .brown(brown),
    .pin_low(pin_low), .supply_adequate(sup_ok),
    .supply_below_brown_out(below), .external_reset_pin_n(pin_n),
    .osc_input(osc));

  // Short counts keep the run brief
  rss_reset_sequencer #(.POWER_UP_TIMER_CYCLES(PW), .BOD_CYCLES(4),
    .OST_CYCLES(OS), .FILTER_CYCLES(3), .RETAIN_W(8)) uut (
    .mclk(mclk), .rstn(rstn), .osc_mode_sel(mode),
    .power_up_timer_disable_bit(pdis), .brown_out_enable_bit(bod_en),
    .reset_pin_function_bit(rpf), .external_reset_pin_n(pin_n),
    .supply_adequate(sup_ok), .supply_below_brown_out(below),
    .osc_input(osc), .watchdog_timeout(wdt), .sleeping(slp),
    .sleep_cmd(scmd), .clear_watchdog_cmd(ccmd), .retain_we(we),
    .retain_wdata(wdata), .retain_rdata(rdata), .core_reset_n(crst_n),
    .core_run(crun), .wake_pulse(wake), .timeout_flag(to_f),
    .power_down_flag(pd_f), .reset_cause(cause), .gpio_pin_in(gpio),
    .clock_output_pin(ck), .clock_output_oe(ck_oe));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Counts edges until core reset lifts; bounded against a hang
  task automatic wait_run();
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (crst_n !== 1'b1 && n < 400);
    check(crst_n, 1);
  endtask

  // Power-on pulse, then supply rises after a short while
  task automatic por(input logic [2:0] m, input logic dis);
    rstn <= 1'b0;
    sup_on <= 1'b0;
    mode <= m;
    pdis <= dis;
    exp_q.push_back({rss_pkg::CAUSE_W'(1), 2'h3});
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    sup_on <= 1'b1;
    wait_run();
  endtask

  task automatic pin_pulse(input int len);
    pin_low <= 1'b1;
    repeat (len) @(posedge mclk);
    pin_low <= 1'b0;
  endtask

  task automatic one_cycle_wdt(input logic asleep);
    slp <= asleep;
    wdt <= 1'b1;
    @(posedge mclk);
    wdt <= 1'b0;
    slp <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // Takes the oldest note whenever reset lifts or a wake completes
  always @(posedge mclk)
  begin
    if ((crst_n === 1'b1 && rst_seen === 1'b0) || wake === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'hFF, 32'h0);
      else
        check({cause, to_f, pd_f}, exp_q.pop_front());
    end
    rst_seen <= crst_n;
  end

  // Main sequence
  initial
  begin
    n = $urandom(32'h6964);
    por(3'h1, 1'b0);
    check(n >= PW + OS * 4 - 4 && n <= PW + OS * 4 + 12, 1);
    por(3'h3, 1'b1);
    check(n <= 8, 1);
    for (int m = 0; m < 8; m++)
    begin
      mode <= m[2:0];
      repeat (7) @(posedge mclk);
      check(ck_oe, m == 5 || m == 7);
    end
    // quarter-rate clock changes level every second edge
    n = 0;
    repeat (16)
    begin
      ck_q = ck;
      @(posedge mclk);
      n += (ck != ck_q);
    end
    check(n, 8);
    we <= 1'b1;
    wdata <= 8'($urandom);
    @(posedge mclk);
    we <= 1'b0;
    exp_q.push_back({6'h02, 2'h1});
    one_cycle_wdt(1'b1 == 1'b0);
    wait_run();
    check(rdata, wdata);
    exp_q.push_back({6'h04, 2'h0});
    one_cycle_wdt(1'b1);
    repeat (4) @(posedge mclk);
    check(crst_n, 1);
    // crystal wake waits for the start count, core reset released but core_run held low
    mode <= 3'h1;
    exp_q.push_back({6'h04, 2'h0});
    one_cycle_wdt(1'b1);
    check({crst_n, crun}, 2'b10);
    repeat (50) @(posedge mclk);
    check(crun, 1);
    ccmd <= 1'b1;
    scmd <= 1'b1;
    @(posedge mclk);
    ccmd <= 1'b0;
    scmd <= 1'b0;
    exp_q.push_back({6'h08, 2'h3});
    pin_pulse(8 + $urandom % 8);
    wait_run();
    pin_pulse(1);
    repeat (10) @(posedge mclk);
    check(crst_n, 1);
    rpf <= 1'b0;
    repeat (4) @(posedge mclk);
    pin_pulse(10);
    check({crst_n, gpio}, 2'b10);
    repeat (8) @(posedge mclk);
    check(gpio, 1);
    rpf <= 1'b1;
    repeat (8) @(posedge mclk);
    exp_q.push_back({6'h10, 2'h2});
    slp <= 1'b1;
    pin_pulse(10);
    slp <= 1'b0;
    wait_run();
    // brown-out with the disable bit cleared, so the power-up delay runs
    bod_en <= 1'b1;
    pdis <= 1'b0;
    exp_q.push_back({6'h20, 2'h3});
    brown <= 1'b1;
    repeat (10) @(posedge mclk);
    brown <= 1'b0;
    repeat (10) @(posedge mclk);
    brown <= 1'b1;
    @(posedge mclk);
    brown <= 1'b0;
    wait_run();
    check(n >= PW, 1);
    brown <= 1'b1;
    repeat (2) @(posedge mclk);
    brown <= 1'b0;
    repeat (12) @(posedge mclk);
    check(crst_n, 1);
    check(exp_q.size(), 0);
    print_verdict();
  end

  // Whole run needs about 400 cycles; allow far more
  initial
  begin
    #200us;
    num_errors++;
    print_verdict();
  end
endmodule

// File: verification/rss_supply_model.sv
// Supply comparators, reset pin network and crystal for the sequencer
`timescale 1ns/1ps
module rss_supply_model (
  input  wire logic sup_on,
  input  wire logic brown,
  input  wire logic pin_low,
  output logic      supply_adequate,
  output logic      supply_below_brown_out,
  output logic      external_reset_pin_n,
  output logic      osc_input
);
  // Comparators settle off the clock edge, so they look asynchronous
  assign #3 supply_adequate        = sup_on;
  assign #3 supply_below_brown_out = brown;
  // Pull-up network: pin reads high unless held low from outside
  assign #2 external_reset_pin_n   = !pin_low;
  // Free-running crystal, phase unrelated, slower than mclk/3
  initial
  begin
    osc_input = 1'b0;
    forever #41 osc_input = ~osc_input;
  end
endmodule
